// [logic/xbar_defines.vh]
// register offsets, field positions and reset values for the crossbar selectors
`ifndef XBAR_DEFINES_VH
`define XBAR_DEFINES_VH
`define ROUTE_SEL_4_7_ADDR 32'h4000B1A4
`define ROUTE_SEL_8_11_ADDR 32'h4000B1A8
`define ROUTE_SEL_12_15_ADDR 32'h4000B1AC
`define ROUTE_SEL_RESET 32'h3F3F3F3F
`define ROUTE_SEL_MASK 32'h3F3F3F3F
`define FIELD_W 6
`define FIELD0_LSB 0
`define FIELD1_LSB 8
`define FIELD2_LSB 16
`define FIELD3_LSB 24
`define FIELD_RESET 6'h3F
`define PRIMARY_W 3
`define PRIMARY_CROSSBAR_SLOT 3'h1
`define UNROUTED_CODE 6'h3F
`endif

// [logic/route_word_reg.v]
// one 32-bit selector word holding four 6-bit crossbar fields
`timescale 1ns/1ps
`include "xbar_defines.vh"
module route_word_reg (
    clk,
    reset,
    wr_en,
    wr_data,
    word
);
    input wire clk;
    input wire reset;
    input wire wr_en;
    input wire [31:0] wr_data;
    output reg [31:0] word;

    // unassigned bits masked on write so they read zero
    always @(posedge clk)
    begin
        if (reset)
            word <= `ROUTE_SEL_RESET;
        else if (wr_en)
            word <= wr_data & `ROUTE_SEL_MASK;
    end
endmodule

// [logic/io_crossbar_function_select.v]
// crossbar function selectors for low-power pins 4 to 15
`timescale 1ns/1ps
`include "xbar_defines.vh"
// Functional notes
// - first word: pins 7..4 six-bit fields
// - field routes only when primary select is 1
// - reset value 0x3F3F3F3F in every word
// - second word: pins 11..8 fields
// - third word: pins 15..12 fields
// - primary code 1 means crossbar slot
module io_crossbar_function_select (
    clk,
    reset,
    addr,
    wdata,
    wr,
    rd,
    rdata,
    primary_function_select,
    crossbar_field,
    crossbar_active
);
    parameter NPIN = 12;
    input wire clk;
    input wire reset;
    input wire [31:0] addr;
    input wire [31:0] wdata;
    input wire wr;
    input wire rd;
    output reg [31:0] rdata;
    input wire [NPIN*`PRIMARY_W-1:0] primary_function_select;
    output reg [NPIN*`FIELD_W-1:0] crossbar_field;
    output reg [NPIN-1:0] crossbar_active;

    wire [31:0] word0;
    wire [31:0] word1;
    wire [31:0] word2;
    wire [95:0] words;
    reg [NPIN*`FIELD_W-1:0] field_nxt;
    reg [NPIN-1:0] active_nxt;
    integer i;
    integer j;
    wire hit0;
    wire hit1;
    wire hit2;
    wire wr0;
    wire wr1;
    wire wr2;

    // pin to field map, four pins per selector word
    //   word0: pin 4 bits 5:0, pin 5 bits 13:8
    //   word0: pin 6 bits 21:16, pin 7 bits 29:24
    //   word1: pin 8 bits 5:0, pin 9 bits 13:8
    //   word1: pin 10 bits 21:16, pin 11 bits 29:24
    //   word2: pin 12 bits 5:0, pin 13 bits 13:8
    //   word2: pin 14 bits 21:16, pin 15 bits 29:24
    // bits 31:30, 23:22, 15:14 and 7:6 of every word stay zero
    // output index i serves pin 4+i, so word i/4 and field i%4

    // timing seen from the bus
    //   write: stored at the strobe edge, visible the next cycle
    //   read: data stand in rdata for the one cycle after the strobe
    //   pin codes follow a register or primary change one cycle later
    //   reset: all words back to 0x3F3F3F3F, pins parked, flags clear
    // the pin side is registered so a half-updated word never
    // reaches the pad mux as a glitch
    // unmapped addresses are refused quietly: no write, read gives zero

    // full 32-bit address compare, no aliasing of the word offsets
    function addr_is;
        input [31:0] a;
        input [31:0] target;
        begin
            addr_is = (a == target);
        end
    endfunction

    // primary code that hands the pin to the crossbar slot
    function slot_chosen;
        input [2:0] code;
        begin
            slot_chosen = (code == `PRIMARY_CROSSBAR_SLOT);
        end
    endfunction

    // read data for a one-hot word hit, zero when nothing matched
    function [31:0] read_pick;
        input [2:0] hits;
        input [31:0] w0;
        input [31:0] w1;
        input [31:0] w2;
        begin
            case (hits)
                3'h1: read_pick = w0;
                3'h2: read_pick = w1;
                3'h4: read_pick = w2;
                default: read_pick = 32'h00000000;
            endcase
        end
    endfunction

    // selector word that holds the field of output index n
    function [31:0] word_of;
        input [95:0] all;
        input [3:0] n;
        begin
            case (n[3:2])
                2'h0: word_of = all[31:0];
                2'h1: word_of = all[63:32];
                default: word_of = all[95:64];
            endcase
        end
    endfunction

    // word hits shared by the write enables and the read mux
    assign hit0 = addr_is(addr, `ROUTE_SEL_4_7_ADDR);
    assign hit1 = addr_is(addr, `ROUTE_SEL_8_11_ADDR);
    assign hit2 = addr_is(addr, `ROUTE_SEL_12_15_ADDR);

    // writes to unmapped addresses fall through and change nothing
    assign wr0 = wr & hit0;
    assign wr1 = wr & hit1;
    assign wr2 = wr & hit2;

    // pick field n (0..3) out of a selector word
    function [5:0] field_of;
        input [31:0] w;
        input [1:0] n;
        begin
            case (n)
                2'h0: field_of = w[`FIELD0_LSB +: `FIELD_W];
                2'h1: field_of = w[`FIELD1_LSB +: `FIELD_W];
                2'h2: field_of = w[`FIELD2_LSB +: `FIELD_W];
                default: field_of = w[`FIELD3_LSB +: `FIELD_W];
            endcase
        end
    endfunction

    // three selector words
    route_word_reg u_sel0 (
        .clk(clk),
        .reset(reset),
        .wr_en(wr0),
        .wr_data(wdata),
        .word(word0)
    );
    route_word_reg u_sel1 (
        .clk(clk),
        .reset(reset),
        .wr_en(wr1),
        .wr_data(wdata),
        .word(word1)
    );
    route_word_reg u_sel2 (
        .clk(clk),
        .reset(reset),
        .wr_en(wr2),
        .wr_data(wdata),
        .word(word2)
    );
    assign words = {word2, word1, word0};

    // read data one cycle after the strobe, zero otherwise or when unmapped
    // the word is read as it stood before the edge, so a write and a read of
    // the same word on back-to-back strobes return the new value
    always @(posedge clk)
    begin
        if (reset)
            rdata <= 32'h00000000;
        else if (rd)
            rdata <= read_pick({hit2, hit1, hit0}, word0, word1, word2);
        else
            rdata <= 32'h00000000; // stands for one cycle only
    end

    // slot flag per pin, set while its primary code picks the crossbar slot
    always @*
    begin
        active_nxt = {NPIN{1'b0}};
        for (i = 0; i < NPIN; i = i + 1)
        begin
            active_nxt[i] =
                slot_chosen(primary_function_select[i*`PRIMARY_W +: `PRIMARY_W]);
        end
    end

    // route field to pin only when its slot flag is set; other pins
    // park on the unrouted code so the pad never sees a stale function
    always @*
    begin
        field_nxt = {NPIN*`FIELD_W{1'b0}};
        for (j = 0; j < NPIN; j = j + 1)
        begin
            if (active_nxt[j])
                field_nxt[j*`FIELD_W +: `FIELD_W] =
                    field_of(word_of(words, j[3:0]), j[1:0]);
            else
                field_nxt[j*`FIELD_W +: `FIELD_W] = `UNROUTED_CODE;
        end
    end

    // registered slot flags, cleared by reset
    always @(posedge clk)
    begin
        if (reset)
            crossbar_active <= {NPIN{1'b0}};
        else
            crossbar_active <= active_nxt;
    end

    // registered pin codes, unrouted code during and after reset
    always @(posedge clk)
    begin
        if (reset)
            crossbar_field <= {NPIN{`FIELD_RESET}};
        else
            crossbar_field <= field_nxt;
    end
endmodule

// [bench/xbar_assertions.sv]
// port assertions for the crossbar selector block
`timescale 1ns/1ps
module xbar_chk #(parameter NPIN = 12) (
    input wire clk,
    input wire reset,
    input wire [31:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire [NPIN*3-1:0] primary_function_select,
    input wire [NPIN*6-1:0] crossbar_field,
    input wire [NPIN-1:0] crossbar_active
);
    // pin 4 primary code, used by the slot checks
    wire [2:0] p4 = primary_function_select[2:0];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    property p_rst; disable iff (1'b0) reset |=> rdata == 0 && crossbar_active == 0; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_gap; (rdata & 32'hC0C0C0C0) == 0; endproperty
    a_gap: assert property (p_gap) else $error("gap bits set");
    property p_slot; 1 |=> crossbar_active[0] == ($past(p4) == 3'h1); endproperty
    a_slot: assert property (p_slot) else $error("slot flag wrong");
    property p_route; !crossbar_active[0] |-> crossbar_field[5:0] == 6'h3F; endproperty
    a_route: assert property (p_route) else $error("field routed off slot");
    property p_w1; wr && addr == 32'h4000B1A4 ##1 rd && $stable(addr) |=>
        rdata == ($past(wdata, 2) & 32'h3F3F3F3F); endproperty
    a_w1: assert property (p_w1) else $error("word one readback");
    property p_w2; wr && addr == 32'h4000B1A8 ##1 rd && $stable(addr) |=>
        rdata == ($past(wdata, 2) & 32'h3F3F3F3F); endproperty
    a_w2: assert property (p_w2) else $error("word two readback");
    property p_w3; wr && addr == 32'h4000B1AC ##1 rd && $stable(addr) |=>
        rdata == ($past(wdata, 2) & 32'h3F3F3F3F); endproperty
    a_w3: assert property (p_w3) else $error("word three readback");
endmodule
bind io_crossbar_function_select xbar_chk #(.NPIN(NPIN)) chk (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .primary_function_select(primary_function_select), .crossbar_field(crossbar_field),
    .crossbar_active(crossbar_active));

// [bench/tb_io_crossbar_function_select.sv]
// bench for the crossbar selector block
`timescale 1ns/1ps
module tb_io_crossbar_function_select;
    reg clk = 0;
    reg reset = 1;
    reg [31:0] addr = 0;
    reg [31:0] wdata = 0;
    reg wr = 0;
    reg rd = 0;
    reg [35:0] psel = 0;
    wire [31:0] rdata;
    wire [71:0] field;
    wire [11:0] act;
    integer miscompares = 0;
    integer check_count = 0;
    integer i;
    reg [95:0] rows [0:3];
    always #5 clk = ~clk;
    io_crossbar_function_select uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .primary_function_select(psel),
        .crossbar_field(field), .crossbar_active(act));
    // compare and count
    task chk(input [63:0] nm, input [71:0] seen, input [71:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
        end
    end
    endtask
    // one bus cycle, strobes set at the clock edge
    task acc(input w, input r, input [31:0] a, input [31:0] d);
    begin
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    end
    endtask
    task results;
    begin
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    // write then read back each row, unmapped last
    initial
    begin
        rows[0] = {32'h4000B1A4, 32'hFFC0C0C7, 32'h3F000007};
        rows[1] = {32'h4000B1A8, 32'h01020304, 32'h01020304};
        rows[2] = {32'h4000B1AC, 32'hC1C2C3C4, 32'h01020304};
        rows[3] = {32'h4000B1B0, 32'h12345678, 32'h00000000};
        repeat (16) @(posedge clk);
        reset <= 0;
        for (i = 0; i < 4; i = i + 1)
        begin
            acc(1, 0, rows[i][95:64], rows[i][63:32]);
            acc(0, 1, rows[i][95:64], 0);
            acc(0, 0, 0, 0);
            #1 chk("rdata", rdata, rows[i][31:0]);
            @(posedge clk) #1 chk("rdone", rdata, 32'h00000000);
        end
        // pin 4 and pin 8 on the slot, pin 9 on another code
        @(posedge clk) psel <= 36'h000011001;
        repeat (2) @(posedge clk);
        #1 chk("field", field, {{7{6'h3F}}, 6'h04, {3{6'h3F}}, 6'h07});
        chk("active", act, 12'h011);
        // second reset in mid-run
        @(posedge clk) reset <= 1;
        @(posedge clk) reset <= 0;
        #1 chk("rfield", field, {12{6'h3F}});
        chk("ract", act, 12'h000);
        acc(0, 1, 32'h4000B1AC, 0);
        acc(0, 0, 0, 0);
        #1 chk("rword", rdata, 32'h3F3F3F3F);
        results;
    end
    // watchdog
    initial
    begin
        #5000;
        miscompares = miscompares + 1;
        results;
    end
endmodule
